// [hdl/tmz_pkg.sv]
// Package with register map, field positions and reset values for the timer block
package tmz_pkg;
    // Register byte addresses, one aligned word each
    localparam logic [3:0] ADDR_TIMER_CONTROL      = 4'h0;
    localparam logic [3:0] ADDR_COUNT_LOW_BYTE     = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HIGH_BUFFER  = 4'h8;
    localparam logic [3:0] ADDR_INTERRUPT_CONTROL  = 4'hc;
    // Timer control fields
    localparam int         BIT_RUN_ENABLE          = 7;
    localparam int         BIT_WIDTH_SELECT        = 6;
    localparam int         BIT_SOURCE_SELECT       = 5;
    localparam int         BIT_EDGE_SELECT         = 4;
    localparam int         BIT_PRESCALER_BYPASS    = 3;
    localparam int         BIT_RATIO_MSB           = 2;
    // Interrupt control fields
    localparam int         BIT_OVERFLOW_IRQ_ENABLE = 5;
    localparam int         BIT_OVERFLOW_FLAG       = 2;
    // Reset values, write hold and pin arm cycle counts
    localparam logic [7:0] RST_TIMER_CONTROL       = 8'hff;
    localparam logic [7:0] RST_COUNT_HIGH_BUFFER   = 8'h00;
    localparam logic [7:0] RST_COUNT_LOW_BYTE      = 8'h00;
    localparam logic [7:0] RST_PRESCALER           = 8'h00;
    localparam logic [1:0] WRITE_HOLD_CYCLES       = 2'h2;
    localparam logic [1:0] PIN_ARM_CYCLES          = 2'h3;
    // Bus slave states
    typedef enum logic [1:0] {
        TMZ_IDLE = 2'b00,
        TMZ_ACK  = 2'b01
    } tmz_bus_t;
endpackage : tmz_pkg

// [hdl/tmz_timer.sv]
// Timer0 style 8/16-bit timer/counter with prescaler and Wishbone register slave
// Functional notes
// - Count only while run enable set
// - Width select one means 8-bit counter
// - Source select picks pin or instruction cycles
// - Timer mode without prescaler counts every cycle
// - Low byte write inhibits two increments
// - Edge select zero rising, one falling
// - Pin synchronised before use, adds delay
// - Prescaler eight bits, not software visible
// - Bypass bit zero routes through prescaler
// - Ratio code 000 divides 2, doubling
// - Low write clears prescaler, keeps assignment
// - Assignment may change while running
// - Flag set on FFh or FFFFh wrap
// - Interrupt request gated by enable bit
// - Timer stopped during sleep
// - Low read copies true high byte
// - True high byte reached only via buffer
// - Low write loads high from buffer
// - High buffer cleared on any reset
`timescale 1ns/100ps
module tmz_timer (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_SYS_RST,
    // Wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [3:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // Device pins and status
    input  wire logic        I_EXTERNAL_COUNT_PIN,
    input  wire logic        I_SLEEP,
    output logic             O_IRQ
);
    import tmz_pkg::*;

    tmz_bus_t    bus_q;
    logic [7:0]  timer_control_q;
    logic [7:0]  high_buffer_q;
    logic [15:0] count_q;
    logic [7:0]  prescaler_q;
    logic [1:0]  hold_q;
    logic        flag_q;
    logic        irq_en_q;
    logic        pin_meta_q;
    logic        pin_sync_q;
    logic        pin_prev_q;
    logic [31:0] rdata_q;

    logic        access;
    logic        wr_lane0;
    logic        wr_ctrl;
    logic        wr_low;
    logic        wr_high;
    logic        wr_intc;
    logic        rd_low;
    logic        pin_edge;
    logic        source_event;
    logic        prescale_tick;
    logic        count_event;
    logic        do_increment;
    logic        wrap;
    logic [15:0] count_next;
    logic [7:0]  ratio_mask;
    logic        pin_armed;
    logic [1:0]  pin_arm_q;

    // Take each request once, ack for one cycle
    assign access   = I_WB_CYC && I_WB_STB && (bus_q == TMZ_IDLE);
    assign wr_lane0 = access && I_WB_WE && I_WB_SEL[0];
    assign wr_ctrl  = wr_lane0 && (I_WB_ADR == ADDR_TIMER_CONTROL);
    assign wr_low   = wr_lane0 && (I_WB_ADR == ADDR_COUNT_LOW_BYTE);
    assign wr_high  = wr_lane0 && (I_WB_ADR == ADDR_COUNT_HIGH_BUFFER);
    assign wr_intc  = wr_lane0 && (I_WB_ADR == ADDR_INTERRUPT_CONTROL);
    assign rd_low   = access && !I_WB_WE && (I_WB_ADR == ADDR_COUNT_LOW_BYTE);

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            bus_q <= TMZ_IDLE;
        end else if (access) begin
            bus_q <= TMZ_ACK;
        end else begin
            bus_q <= TMZ_IDLE;
        end
    end
    assign O_WB_ACK = (bus_q == TMZ_ACK);

    // Read data; unmapped addresses read as zero, true high byte never readable
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rdata_q <= 32'h0;
        end else if (access && !I_WB_WE) begin
            case (I_WB_ADR)
                ADDR_TIMER_CONTROL:     rdata_q <= {24'h0, timer_control_q};
                ADDR_COUNT_LOW_BYTE:    rdata_q <= {24'h0, count_q[7:0]};
                ADDR_COUNT_HIGH_BUFFER: rdata_q <= {24'h0, high_buffer_q};
                ADDR_INTERRUPT_CONTROL: rdata_q <= {24'h0, 2'b00, irq_en_q, 2'b00, flag_q, 2'b00};
                default:                rdata_q <= 32'h0;
            endcase
        end
    end
    assign O_WB_DAT = rdata_q;

    // Control register; writable any time, even while counting
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            timer_control_q <= RST_TIMER_CONTROL;
        end else if (wr_ctrl) begin
            timer_control_q <= I_WB_DAT[7:0];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            irq_en_q <= 1'b0;
        end else if (wr_intc) begin
            irq_en_q <= I_WB_DAT[BIT_OVERFLOW_IRQ_ENABLE];
        end
    end

    // High buffer: loaded by software or snapshotted on low reads
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            high_buffer_q <= RST_COUNT_HIGH_BUFFER;
        end else if (rd_low) begin
            high_buffer_q <= count_q[15:8];
        end else if (wr_high) begin
            high_buffer_q <= I_WB_DAT[7:0];
        end
    end

    // Two-stage synchroniser, edge detect only on the second stage
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= I_EXTERNAL_COUNT_PIN;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end
    // History flop is trusted only once it holds a real sample; a pin that idles
    // high would otherwise look like a rising edge straight after reset
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            pin_arm_q <= 2'h0;
        end else if (pin_arm_q != PIN_ARM_CYCLES) begin
            pin_arm_q <= pin_arm_q + 2'h1;
        end
    end
    assign pin_armed = (pin_arm_q == PIN_ARM_CYCLES);
    assign pin_edge  = pin_armed && (timer_control_q[BIT_EDGE_SELECT] ? (pin_prev_q && !pin_sync_q)
                                                                      : (!pin_prev_q && pin_sync_q));

    // Count source; sleep halts the prescaler and counter so no wake-up by overflow
    assign source_event = !I_SLEEP && (timer_control_q[BIT_SOURCE_SELECT] ? pin_edge : 1'b1);

    // Ratio mask: code n divides by 2^(n+1)
    assign ratio_mask    = 8'hff >> (3'h7 - timer_control_q[BIT_RATIO_MSB:0]);
    assign prescale_tick = ((prescaler_q & ratio_mask) == ratio_mask);

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            prescaler_q <= RST_PRESCALER;
        end else if (wr_low) begin
            prescaler_q <= RST_PRESCALER;
        end else if (source_event && timer_control_q[BIT_RUN_ENABLE]) begin
            prescaler_q <= prescaler_q + 8'h01;
        end
    end

    assign count_event = timer_control_q[BIT_PRESCALER_BYPASS] ? source_event
                                                                : (source_event && prescale_tick);
    assign do_increment = count_event && timer_control_q[BIT_RUN_ENABLE] && (hold_q == 2'h0);

    // Inhibit window after a low byte write
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            hold_q <= 2'h0;
        end else if (wr_low) begin
            hold_q <= WRITE_HOLD_CYCLES;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    // 8-bit mode leaves the high byte untouched
    always_comb begin
        count_next = count_q;
        wrap       = 1'b0;
        if (timer_control_q[BIT_WIDTH_SELECT]) begin
            count_next[7:0] = count_q[7:0] + 8'h01;
            wrap            = (count_q[7:0] == 8'hff);
        end else begin
            count_next = count_q + 16'h0001;
            wrap       = (count_q == 16'hffff);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            count_q <= {RST_COUNT_HIGH_BUFFER, RST_COUNT_LOW_BYTE};
        end else if (wr_low) begin
            count_q <= {high_buffer_q, I_WB_DAT[7:0]};
        end else if (do_increment) begin
            count_q <= count_next;
        end
    end

    // Overflow flag; set wins over a same-cycle clear
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            flag_q <= 1'b0;
        end else if (do_increment && !wr_low && wrap) begin
            flag_q <= 1'b1;
        end else if (wr_intc) begin
            flag_q <= I_WB_DAT[BIT_OVERFLOW_FLAG];
        end
    end

    assign O_IRQ = flag_q && irq_en_q;

    // Assertions
    a_halt_freezes_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!timer_control_q[BIT_RUN_ENABLE] && !wr_low) |=> $stable(count_q))
        else $error("count moved while stopped");
    a_width_keeps_high: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[BIT_WIDTH_SELECT] && !wr_low) |=> $stable(count_q[15:8]))
        else $error("high byte moved in 8-bit mode");
    a_timer_every_cycle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[7:3] == 5'b10001 && !I_SLEEP && hold_q == 2'h0 && !wr_low)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("timer did not step");
    sequence s_low_write;
        wr_low;
    endsequence
    a_write_inhibit: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_low_write ##1 !wr_low |=> $stable(count_q))
        else $error("increment during inhibit");
    a_prescaler_clear: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_low |=> (prescaler_q == 8'h00) && $stable(timer_control_q[BIT_PRESCALER_BYPASS]))
        else $error("prescaler not cleared");
    a_sleep_stops: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_SLEEP && !wr_low) |=> $stable(count_q))
        else $error("counted in sleep");
    a_overflow_flag: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (do_increment && wrap && !wr_low) |=> flag_q && count_q[7:0] == 8'h00)
        else $error("overflow flag missed");
    a_irq_gated: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!irq_en_q && !wr_intc && do_increment && wrap && !wr_low) |=> flag_q && !O_IRQ)
        else $error("irq not gated");
    a_low_read_snap: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        rd_low |=> high_buffer_q == $past(count_q[15:8]))
        else $error("high byte not captured");
    a_atomic_load: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_low |=> count_q == {$past(high_buffer_q), $past(I_WB_DAT[7:0])})
        else $error("16-bit load wrong");

    // Bus slave: one answer per request, never two in a row
    a_ack_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");

    a_ack_answer: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK)
        else $error("request not answered");

    a_read_top_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_WB_ACK |-> (O_WB_DAT[31:8] == 24'h0))
        else $error("upper read bits not zero");

    // Register writes land in the cycle after the request is taken
    a_ctrl_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_ctrl |=> timer_control_q == $past(I_WB_DAT[7:0]))
        else $error("control write lost");

    a_high_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_high |=> high_buffer_q == $past(I_WB_DAT[7:0]))
        else $error("buffer write lost");

    a_flag_clear: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (wr_intc && !I_WB_DAT[BIT_OVERFLOW_FLAG] && !(do_increment && wrap && !wr_low)) |=> !flag_q)
        else $error("flag not cleared");

    // Inhibit window covers both cycles after the low write
    a_hold_blocks: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (hold_q != 2'h0 && !wr_low) |=> $stable(count_q))
        else $error("count moved in hold window");

    // Prescaler path: free count of source events, ticks at the ratio
    a_prescale_step: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (source_event && timer_control_q[BIT_RUN_ENABLE] && !wr_low) |=> prescaler_q == $past(prescaler_q) + 8'h01)
        else $error("prescaler did not step");

    a_prescale_gate: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!timer_control_q[BIT_PRESCALER_BYPASS] && !prescale_tick && !wr_low) |=> $stable(count_q))
        else $error("count moved between ticks");

    a_bypass_step: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[BIT_PRESCALER_BYPASS] && timer_control_q[BIT_RUN_ENABLE] && source_event
         && hold_q == 2'h0 && !wr_low) |=> count_q != $past(count_q))
        else $error("bypass did not count");

    a_ratio_low: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[BIT_RATIO_MSB:0] == 3'h0) |-> (ratio_mask == 8'h01))
        else $error("ratio 2 mask wrong");

    a_ratio_high: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[BIT_RATIO_MSB:0] == 3'h7) |-> (ratio_mask == 8'hff))
        else $error("ratio 256 mask wrong");

    a_sleep_prescaler: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_SLEEP && !wr_low) |=> $stable(prescaler_q))
        else $error("prescaler ran in sleep");

    // Carry into the high byte only in 16-bit mode
    a_carry_16: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!timer_control_q[BIT_WIDTH_SELECT] && do_increment && !wr_low && count_q[7:0] == 8'hff)
        |=> count_q[15:8] == $past(count_q[15:8]) + 8'h01)
        else $error("high byte missed carry");

    // Pin path: synchroniser depth and the selected edge
    a_sync_two: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        pin_armed |-> pin_sync_q == $past(I_EXTERNAL_COUNT_PIN, 2))
        else $error("synchroniser depth wrong");

    a_source_pin: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (timer_control_q[BIT_SOURCE_SELECT] && !pin_edge && !wr_low) |=> $stable(count_q))
        else $error("counted without pin edge");

    sequence s_rise_counted;
        pin_armed && !pin_prev_q && pin_sync_q && !timer_control_q[BIT_EDGE_SELECT]
        && timer_control_q[BIT_SOURCE_SELECT] && timer_control_q[BIT_PRESCALER_BYPASS]
        && timer_control_q[BIT_RUN_ENABLE] && !I_SLEEP && (hold_q == 2'h0) && !wr_low;
    endsequence

    sequence s_fall_counted;
        pin_armed && pin_prev_q && !pin_sync_q && timer_control_q[BIT_EDGE_SELECT]
        && timer_control_q[BIT_SOURCE_SELECT] && timer_control_q[BIT_PRESCALER_BYPASS]
        && timer_control_q[BIT_RUN_ENABLE] && !I_SLEEP && (hold_q == 2'h0) && !wr_low;
    endsequence

    a_edge_rise: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_rise_counted |=> count_q != $past(count_q))
        else $error("rising edge not counted");

    a_edge_fall: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_fall_counted |=> count_q != $past(count_q))
        else $error("falling edge not counted");
endmodule : tmz_timer

// [tb/tmz_pin_src.sv]
// Model of the external count source that drives the count pin
`timescale 1ns/100ps
module tmz_pin_src (
    // Clock
    input  wire logic I_CLK,
    // Count pin
    output logic      O_PIN
);
    initial O_PIN = 1'b0;
    // Slow source: a level is held many cycles so the synchroniser always sees it
    task automatic drive(input logic lvl, input int hold);
        @(posedge I_CLK);
        O_PIN <= lvl;
        repeat (hold) @(posedge I_CLK);
    endtask : drive
endmodule : tmz_pin_src

// [tb/tmz_timer_tb_top.sv]
// Self-checking bench for the timer block
`timescale 1ns/100ps
module tmz_timer_tb_top;
    import tmz_pkg::*;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  adr   = 4'h0;
    logic [3:0]  sel   = 4'h1;
    logic [31:0] wdat  = 32'h0;
    logic        sleep = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        pin;
    logic        irq;
    logic [7:0]  q0, q1, q2, junk;
    logic [15:0] v;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          ack_at, w, r;
    always #25 clk = ~clk;
    tmz_timer dut (.I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
                   .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
                   .I_EXTERNAL_COUNT_PIN(pin), .I_SLEEP(sleep), .O_IRQ(irq));
    tmz_pin_src src (.I_CLK(clk), .O_PIN(pin));
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] got);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_rng
    // Classic single cycle; ack is read before the edge's own updates land
    task automatic bus(input logic wr_en, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= wr_en; adr <= a; wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        ack_at = cycles;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            $display("BAD ack expected 1 seen %b", ack);
        end
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, junk);
    endtask : wr
    task automatic t_reset();
        bus(1'b0, ADDR_TIMER_CONTROL, 8'h00, q0); chk("control", RST_TIMER_CONTROL, q0);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q0); chk("buffer", 8'h00, q0);
        bus(1'b0, ADDR_INTERRUPT_CONTROL, 8'h00, q0); chk("irq bits", 8'h00, q0 & 8'h24);
        bus(1'b0, 4'h2, 8'h00, q0); chk("unmapped", 8'h00, q0);
        $display("Test reset done");
    endtask : t_reset
    task automatic t_buffer();
        wr(ADDR_TIMER_CONTROL, 8'h08);
        wr(ADDR_COUNT_HIGH_BUFFER, 8'ha5);
        wr(ADDR_COUNT_LOW_BYTE, 8'h3c);
        bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0); chk("low", 8'h3c, q0);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q0); chk("high", 8'ha5, q0);
        wr(ADDR_COUNT_HIGH_BUFFER, 8'h00);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q0); chk("buffer only", 8'h00, q0);
        bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q0); chk("high copy", 8'ha5, q0);
        $display("Test buffer done");
    endtask : t_buffer
    task automatic t_timer();
        wr(ADDR_TIMER_CONTROL, 8'h88);
        wr(ADDR_COUNT_HIGH_BUFFER, 8'h12);
        wr(ADDR_COUNT_LOW_BYTE, 8'hfe); w = ack_at;
        bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0); r = ack_at;
        v = 16'h12fe + 16'(r - w - 3);
        chk("low after write", v[7:0], q0);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q0);
        bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q1);
        v = v + 16'(ack_at - r);
        chk("low running", v[7:0], q1);
        bus(1'b0, ADDR_COUNT_HIGH_BUFFER, 8'h00, q1); chk("carry", v[15:8], q1);
        $display("Test timer done");
    endtask : t_timer
    task automatic t_counter();
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_TIMER_CONTROL, e[0] ? 8'hb8 : 8'ha8);
            src.drive(1'b0, 8);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0);
            src.drive(1'b1, 8);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q1);
            chk("rising", e[0] ? 8'h00 : 8'h01, q1 - q0);
            src.drive(1'b0, 8);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q2);
            chk("falling", e[0] ? 8'h01 : 8'h00, q2 - q1);
        end
        $display("Test counter done");
    endtask : t_counter
    task automatic t_prescale();
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_TIMER_CONTROL, 8'hc0 | 8'(k));
            wr(ADDR_COUNT_LOW_BYTE, 8'h00); w = ack_at;
            repeat (6 << (k + 1)) @(posedge clk);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0);
            chk_rng("ticks", (ack_at - w - 4) >> (k + 1), (ack_at - w) >> (k + 1), q0);
        end
        $display("Test prescale done");
    endtask : t_prescale
    task automatic t_overflow();
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_TIMER_CONTROL, i ? 8'h08 : 8'h48);
            wr(ADDR_INTERRUPT_CONTROL, 8'h20);
            wr(ADDR_COUNT_HIGH_BUFFER, i ? 8'hff : 8'h00);
            wr(ADDR_COUNT_LOW_BYTE, 8'hf0);
            wr(ADDR_TIMER_CONTROL, i ? 8'h88 : 8'hc8);
            repeat (40) @(posedge clk);
            bus(1'b0, ADDR_INTERRUPT_CONTROL, 8'h00, q0); chk("flag", 8'h24, q0 & 8'h24);
            chk("irq", 8'h01, {7'h0, irq});
        end
        wr(ADDR_TIMER_CONTROL, 8'hc8);
        wr(ADDR_INTERRUPT_CONTROL, 8'h00);
        // Masked: an 8-bit wrap still latches the flag within 300 cycles
        repeat (300) @(posedge clk);
        bus(1'b0, ADDR_INTERRUPT_CONTROL, 8'h00, q0); chk("masked flag", 8'h04, q0 & 8'h24);
        chk("masked irq", 8'h00, {7'h0, irq});
        $display("Test overflow done");
    endtask : t_overflow
    task automatic t_hold();
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_TIMER_CONTROL, s ? 8'h08 : 8'h88);
            sleep <= (s == 0);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q0);
            repeat (10) @(posedge clk);
            bus(1'b0, ADDR_COUNT_LOW_BYTE, 8'h00, q1);
            chk(s ? "stopped" : "sleep", q0, q1);
            sleep <= 1'b0;
        end
        $display("Test hold done");
    endtask : t_hold
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_buffer();
        t_timer();
        t_counter();
        t_prescale();
        t_overflow();
        t_hold();
        finish_test();
    end
endmodule : tmz_timer_tb_top
